// ===== rtl/wdr_pkg.sv
package wdr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h60;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h61;

    ////////////////////////////////////////////////////////////////////////////
    // watchdog_control bit positions
    localparam int CTL_IRQ_FLAG = 7;
    localparam int CTL_IRQ_ENABLE = 6;
    localparam int CTL_SEL_HI = 5;
    localparam int CTL_UNLOCK = 4;
    localparam int CTL_RESET_ENABLE = 3;
    localparam int CTL_SEL_LO_MSB = 2;
    localparam int CTL_SEL_LO_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset_cause_status bit positions
    localparam int STS_TEST_PORT = 4;
    localparam int STS_TIMEOUT = 3;
    localparam int STS_BROWNOUT = 2;
    localparam int STS_PIN = 1;
    localparam int STS_POWERON = 0;
    localparam int STS_WIDTH = 5;
    localparam logic [2:0] STS_RESERVED = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RD_DATA_RESET = 8'h00;
    localparam logic [4:0] CAUSE_RESET = 5'h00;
    localparam logic [3:0] SELECT_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0] UNLOCK_NONE = 3'h0;
    localparam logic [2:0] UNLOCK_STEP = 3'h1;
    localparam int CNT_W = 21;
    localparam logic [20:0] BASE_CYCLES = 21'h000800;
    localparam logic [20:0] CNT_ONE = 21'h000001;
    localparam logic [20:0] CNT_ZERO = 21'h000000;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int SYNC_W = 2;
    localparam int SYNC_OSC = 0;
    localparam int SYNC_FUSE = 1;

    ////////////////////////////////////////////////////////////////////////////
    // operating modes
    typedef enum logic [3:0] {
        MODE_STOPPED = 4'b0001,
        MODE_IRQ = 4'b0010,
        MODE_RESET = 4'b0100,
        MODE_IRQ_RESET = 4'b1000
    } wdr_mode_t;

endpackage : wdr_pkg

// ===== rtl/wdr_sync.sv
`timescale 1ns/1ps
module wdr_sync
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // asynchronous levels
    input wire logic [wdr_pkg::SYNC_W-1:0] asyncIn,
    // synchronised levels
    output logic [wdr_pkg::SYNC_W-1:0] syncOut
);

    typedef struct packed {
        logic [wdr_pkg::SYNC_W-1:0] stage1;
        logic [wdr_pkg::SYNC_W-1:0] stage2;
    } wdr_sync_state_t;

    wdr_sync_state_t q;
    wdr_sync_state_t d;

    always_comb
    begin
        d = q;
        d.stage1 = asyncIn;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign syncOut = q.stage2;

endmodule : wdr_sync

// ===== rtl/wdr_timeout_counter.sv
`timescale 1ns/1ps
module wdr_timeout_counter
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic tickPulse,
    input wire logic restart,
    input wire logic run,
    input wire logic [3:0] timeoutSelect,
    // result
    output logic timeoutPulse
);

    typedef struct packed {
        logic [wdr_pkg::CNT_W-1:0] count;
        logic timeout;
    } wdr_cnt_state_t;

    wdr_cnt_state_t q;
    wdr_cnt_state_t d;

    // reserved codes fall back to the longest period rather than never firing
    function automatic logic [wdr_pkg::CNT_W-1:0] limitFor(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > wdr_pkg::SEL_MAX) ? wdr_pkg::SEL_MAX : sel;
        return wdr_pkg::BASE_CYCLES << s;
    endfunction : limitFor

    always_comb
    begin
        d = q;
        d.timeout = 1'b0;
        if (restart || !run)
        begin
            d.count = wdr_pkg::CNT_ZERO;
        end
        else if (tickPulse)
        begin
            if (q.count == limitFor(timeoutSelect) - wdr_pkg::CNT_ONE)
            begin
                d.count = wdr_pkg::CNT_ZERO;
                d.timeout = 1'b1;
            end
            else
            begin
                d.count = q.count + wdr_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign timeoutPulse = q.timeout;

endmodule : wdr_timeout_counter

// ===== rtl/wdr_watchdog.sv
`timescale 1ns/1ps
module wdr_watchdog
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register access
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // processor side
    input wire logic globalIrqEnable,
    input wire logic irqAck,
    input wire logic restartStrobe,
    output logic irqRequest,
    // reset sources and result
    input wire logic porEvent,
    input wire logic pinResetEvent,
    input wire logic brownoutEvent,
    input wire logic testPortResetEvent,
    output logic sysResetPulse,
    // pins
    input wire logic wdtOscIn,
    input wire logic alwaysOnFuse
);

    typedef struct packed {
        logic irqFlag;
        logic irqEnable;
        logic [3:0] timeoutSelect;
        logic [2:0] unlockCnt;
        logic resetEnable;
        logic [wdr_pkg::STS_WIDTH-1:0] cause;
        logic sysReset;
        logic [7:0] rdData;
        logic oscPrev;
    } wdr_main_state_t;

    wdr_main_state_t q;
    wdr_main_state_t d;

    logic [wdr_pkg::SYNC_W-1:0] syncOut;
    logic fuse;
    logic oscLevel;
    logic tick;
    logic timeout;
    logic run;
    logic restart;
    logic ctrlWr;
    logic causeWr;
    logic unlocked;
    logic toReset;
    logic toIrq;
    logic extReset;
    logic anyReset;
    logic irqClear;
    wdr_pkg::wdr_mode_t mode;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic wdr_pkg::wdr_mode_t modeOf(input logic f, input logic rst,
                                                 input logic irq);
        wdr_pkg::wdr_mode_t m;
        m = wdr_pkg::MODE_RESET;
        if (!f)
        begin
            case ({rst, irq})
                2'b00: m = wdr_pkg::MODE_STOPPED;
                2'b01: m = wdr_pkg::MODE_IRQ;
                2'b10: m = wdr_pkg::MODE_RESET;
                2'b11: m = wdr_pkg::MODE_IRQ_RESET;
                default: m = wdr_pkg::MODE_RESET;
            endcase
        end
        return m;
    endfunction : modeOf

    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction : isAddr

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and oscillator counter

    wdr_sync u_sync
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .asyncIn({alwaysOnFuse, wdtOscIn}),
        .syncOut(syncOut)
    );

    wdr_timeout_counter u_counter
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .tickPulse(tick),
        .restart(restart),
        .run(run),
        .timeoutSelect(q.timeoutSelect),
        .timeoutPulse(timeout)
    );

    assign fuse = syncOut[wdr_pkg::SYNC_FUSE];
    assign oscLevel = syncOut[wdr_pkg::SYNC_OSC];
    assign tick = oscLevel & ~q.oscPrev;

    ////////////////////////////////////////////////////////////////////////////
    // mode and time-out action

    assign mode = modeOf(fuse, q.resetEnable, q.irqEnable);
    assign run = (mode != wdr_pkg::MODE_STOPPED);
    assign toReset = timeout && ((mode == wdr_pkg::MODE_RESET) ||
                     ((mode == wdr_pkg::MODE_IRQ_RESET) && q.irqFlag));
    assign toIrq = timeout && ((mode == wdr_pkg::MODE_IRQ) ||
                   ((mode == wdr_pkg::MODE_IRQ_RESET) && !q.irqFlag));
    assign extReset = porEvent | pinResetEvent | brownoutEvent | testPortResetEvent;
    assign anyReset = extReset | toReset;
    assign restart = restartStrobe | anyReset;
    assign ctrlWr = regWrEn && isAddr(regAddr, wdr_pkg::ADDR_CONTROL);
    assign causeWr = regWrEn && isAddr(regAddr, wdr_pkg::ADDR_RESET_CAUSE);
    assign unlocked = (q.unlockCnt != wdr_pkg::UNLOCK_NONE);
    assign irqClear = (ctrlWr && regWrData[wdr_pkg::CTL_IRQ_FLAG]) || irqAck;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        d.sysReset = toReset;
        d.oscPrev = oscLevel;

        // reset causes: clears first, then sets so a coincident event wins
        if (causeWr)
        begin
            d.cause = q.cause & regWrData[wdr_pkg::STS_WIDTH-1:0];
        end
        if (porEvent)
        begin
            d.cause = wdr_pkg::CAUSE_RESET;
        end
        d.cause[wdr_pkg::STS_POWERON] = d.cause[wdr_pkg::STS_POWERON] | porEvent;
        d.cause[wdr_pkg::STS_PIN] = d.cause[wdr_pkg::STS_PIN] | pinResetEvent;
        d.cause[wdr_pkg::STS_BROWNOUT] = d.cause[wdr_pkg::STS_BROWNOUT] | brownoutEvent;
        d.cause[wdr_pkg::STS_TIMEOUT] = d.cause[wdr_pkg::STS_TIMEOUT] | toReset;
        d.cause[wdr_pkg::STS_TEST_PORT] =
            d.cause[wdr_pkg::STS_TEST_PORT] | testPortResetEvent;

        if (anyReset)
        begin
            // any system reset returns control to its initial values, but the time-out flag or fuse keeps reset-enable set
            d.irqFlag = 1'b0;
            d.irqEnable = 1'b0;
            d.timeoutSelect = wdr_pkg::SELECT_RESET;
            d.unlockCnt = wdr_pkg::UNLOCK_NONE;
            d.resetEnable = 1'b0;
        end
        else
        begin
            if (unlocked)
            begin
                d.unlockCnt = q.unlockCnt - wdr_pkg::UNLOCK_STEP;
            end
            if (irqAck && (mode == wdr_pkg::MODE_IRQ_RESET))
            begin
                d.irqEnable = 1'b0;
            end
            if (ctrlWr)
            begin
                d.irqEnable = regWrData[wdr_pkg::CTL_IRQ_ENABLE];
                if (unlocked)
                begin
                    d.resetEnable = regWrData[wdr_pkg::CTL_RESET_ENABLE];
                    d.timeoutSelect = {regWrData[wdr_pkg::CTL_SEL_HI],
                        regWrData[wdr_pkg::CTL_SEL_LO_MSB:wdr_pkg::CTL_SEL_LO_LSB]};
                    d.unlockCnt = wdr_pkg::UNLOCK_NONE;
                end
                else
                begin
                    // locked: reset-enable may only be raised
                    d.resetEnable = q.resetEnable | regWrData[wdr_pkg::CTL_RESET_ENABLE];
                end
                if (regWrData[wdr_pkg::CTL_UNLOCK] && regWrData[wdr_pkg::CTL_RESET_ENABLE])
                begin
                    d.unlockCnt = wdr_pkg::UNLOCK_CYCLES;
                end
            end
            // set wins over clear
            d.irqFlag = (q.irqFlag & ~irqClear) | toIrq;
        end

        d.resetEnable = d.resetEnable | d.cause[wdr_pkg::STS_TIMEOUT] | fuse;
        d.irqEnable = d.irqEnable & ~fuse;

        if (regRdEn)
        begin
            if (isAddr(regAddr, wdr_pkg::ADDR_CONTROL))
            begin
                d.rdData = {q.irqFlag, q.irqEnable, q.timeoutSelect[3], unlocked,
                            q.resetEnable, q.timeoutSelect[2:0]};
            end
            else if (isAddr(regAddr, wdr_pkg::ADDR_RESET_CAUSE))
            begin
                d.rdData = {wdr_pkg::STS_RESERVED, q.cause};
            end
            else
            begin
                d.rdData = wdr_pkg::RD_DATA_RESET;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign regRdData = q.rdData;
    assign sysResetPulse = q.sysReset;
    assign irqRequest = q.irqFlag & q.irqEnable & globalIrqEnable;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence seqUnlockWrite;
        ctrlWr && regWrData[wdr_pkg::CTL_UNLOCK] && regWrData[wdr_pkg::CTL_RESET_ENABLE]
            && !anyReset;
    endsequence

    sequence seqQuiet3;
        (!ctrlWr && !anyReset) [*3];
    endsequence

    AST_UNLOCK_HOLD: assert property (seqUnlockWrite ##1 seqQuiet3 |-> unlocked)
        else $error("unlock window shorter than four cycles");

    AST_UNLOCK_EXPIRE: assert property ($rose(unlocked) ##0 (!ctrlWr) [*4] |=> !unlocked)
        else $error("unlock did not clear after four cycles");

    AST_LOCKED_CHANGE: assert property (ctrlWr && !unlocked && !anyReset && q.resetEnable
        |=> q.resetEnable && $stable(q.timeoutSelect))
        else $error("locked write changed reset enable or prescaler");

    AST_RESET_PULSE: assert property (toReset |=> sysResetPulse ##1 !sysResetPulse)
        else $error("reset pulse not exactly one cycle");

    AST_TIMEOUT_FLAG: assert property (toReset |=> q.cause[wdr_pkg::STS_TIMEOUT]
        && q.resetEnable)
        else $error("watchdog reset flag not set after reset");

    AST_WDE_FORCED: assert property (q.cause[wdr_pkg::STS_TIMEOUT] |-> q.resetEnable)
        else $error("reset enable low while watchdog reset flag set");

    AST_IRQ_FLAG_SET: assert property (timeout && (mode == wdr_pkg::MODE_IRQ) |=> q.irqFlag
        && !sysResetPulse)
        else $error("interrupt mode time-out did not set flag");

    AST_COMBINED_RESET: assert property (timeout && (mode == wdr_pkg::MODE_IRQ_RESET)
        && q.irqFlag |=> sysResetPulse)
        else $error("unserviced combined-mode time-out gave no reset");

    AST_ACK_CLEARS: assert property (irqAck && !timeout && !anyReset
        && (mode == wdr_pkg::MODE_IRQ_RESET) && !ctrlWr |=> !q.irqFlag && !q.irqEnable)
        else $error("vector did not clear flag and enable");

    AST_FUSE_RESET: assert property (fuse && timeout |=> sysResetPulse && !q.irqEnable)
        else $error("fuse did not force reset mode");

    AST_POR_FLAGS: assert property (porEvent && !pinResetEvent && !brownoutEvent
        && !testPortResetEvent |=> q.cause[wdr_pkg::STS_POWERON]
        && !q.cause[wdr_pkg::STS_PIN] && !q.cause[wdr_pkg::STS_TIMEOUT])
        else $error("power-on did not set its flag or clear others");

    AST_IRQ_GATE: assert property (irqRequest |-> globalIrqEnable ##1 1'b1)
        else $error("interrupt requested without global enable");

endmodule : wdr_watchdog

// ===== dv/wdr_watchdog_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module wdr_watchdog_tb;

    localparam logic [7:0] CTL = wdr_pkg::ADDR_CONTROL;
    localparam logic [7:0] CS = wdr_pkg::ADDR_RESET_CAUSE;
    // oscillator period in system clocks, slow enough for the synchroniser
    localparam int OSC_DIV = 4;
    localparam int SLACK = 12;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic globalIrqEnable = 1'b0;
    // por, pin, brownout, test port, ack, restart
    logic [5:0] evt = 6'h00;
    logic irqRequest;
    logic sysResetPulse;
    logic wdtOscIn = 1'b0;
    logic alwaysOnFuse = 1'b0;
    logic [1:0] oscCnt = 2'h0;
    logic [7:0] causeExp [4] = '{8'h01, 8'h03, 8'h07, 8'h17};
    int err_count = 0;
    int samples_checked = 0;
    int n;

    ////////////////////////////////////////////////////////////////////////////
    wdr_watchdog DUT (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .globalIrqEnable(globalIrqEnable),
        .irqAck(evt[4]),
        .restartStrobe(evt[5]),
        .irqRequest(irqRequest),
        .porEvent(evt[0]),
        .pinResetEvent(evt[1]),
        .brownoutEvent(evt[2]),
        .testPortResetEvent(evt[3]),
        .sysResetPulse(sysResetPulse),
        .wdtOscIn(wdtOscIn),
        .alwaysOnFuse(alwaysOnFuse)
    );

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys)
    begin
        oscCnt <= oscCnt + 2'h1;
        wdtOscIn <= oscCnt[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic idle(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : idle

    // every access leaves a free cycle behind it, so strobes never toggle twice
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        `CHK(regRdData, exp);
    endtask : rdchk

    task automatic pulse(input int i);
        @(negedge clk_sys);
        evt[i] = 1'b1;
        @(negedge clk_sys);
        evt[i] = 1'b0;
    endtask : pulse

    task automatic wait_hi(input int s, input int bound, output int cnt);
        cnt = 0;
        while (((s == 0) ? irqRequest : sysResetPulse) !== 1'b1)
        begin
            @(negedge clk_sys);
            cnt++;
            if (cnt > bound)
            begin
                err_count++;
                $display("ERROR %0t: wait ran out", $time);
                wrap_up();
            end
        end
    endtask : wait_hi

    task automatic chk_period(input int cnt, input int edges);
        `CHK((cnt > edges * OSC_DIV - SLACK) && (cnt < edges * OSC_DIV + SLACK), 1'b1);
    endtask : chk_period

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(20);
        reset_n = 1'b1;
        rdchk(CTL, 8'h00);
        rdchk(CS, 8'h00);
        rdchk(8'h62, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 4; i++)
        begin
            pulse(i);
            rdchk(CS, causeExp[i]);
        end
        pulse(0);
        rdchk(CS, 8'h01);
        wr(CS, 8'h00);
        rdchk(CS, 8'h00);
        $display("test reset cause flags done");

        wr(CTL, 8'h08);
        rdchk(CTL, 8'h08);
        wr(CTL, 8'h00);
        rdchk(CTL, 8'h08);
        wr(CTL, 8'h09);
        rdchk(CTL, 8'h08);
        wr(CTL, 8'h18);
        rdchk(CTL, 8'h18);
        wr(CTL, 8'h2F);
        rdchk(CTL, 8'h2F);
        // fifth cycle after unlocking is already too late
        wr(CTL, 8'h18);
        idle(3);
        wr(CTL, 8'h08);
        rdchk(CTL, 8'h2F);
        $display("test timed change done");

        // restart first: the prescaler drops from the longest code to the shortest
        pulse(5);
        wr(CTL, 8'h18);
        wr(CTL, 8'h40);
        globalIrqEnable = 1'b1;
        pulse(5);
        wait_hi(0, 9000, n);
        chk_period(n, 2048);
        globalIrqEnable = 1'b0;
        idle(1);
        `CHK(irqRequest, 1'b0);
        rdchk(CTL, 8'hC0);
        globalIrqEnable = 1'b1;
        idle(1);
        `CHK(irqRequest, 1'b1);
        pulse(4);
        `CHK(irqRequest, 1'b0);
        rdchk(CTL, 8'h40);
        pulse(5);
        wr(CTL, 8'h18);
        wr(CTL, 8'h41);
        pulse(5);
        wait_hi(0, 17000, n);
        chk_period(n, 4096);
        wr(CTL, 8'hC1);
        rdchk(CTL, 8'h41);
        $display("test interrupt mode done");

        wr(CTL, 8'h18);
        wr(CTL, 8'h00);
        pulse(5);
        n = 0;
        repeat (9000)
        begin
            @(negedge clk_sys);
            if (irqRequest !== 1'b0 || sysResetPulse !== 1'b0)
                n++;
        end
        `CHK(n, 0);
        $display("test stopped mode done");

        wr(CTL, 8'h48);
        pulse(5);
        wait_hi(0, 9000, n);
        rdchk(CTL, 8'hC8);
        pulse(4);
        rdchk(CTL, 8'h08);
        wait_hi(1, 9000, n);
        idle(1);
        `CHK(sysResetPulse, 1'b0);
        rdchk(CS, 8'h08);
        rdchk(CTL, 8'h08);
        // re-arm outside any service, then leave the interrupt unserviced
        wr(CTL, 8'h48);
        wait_hi(0, 9000, n);
        wait_hi(1, 9000, n);
        chk_period(n, 2048);
        wr(CTL, 8'h18);
        wr(CTL, 8'h00);
        rdchk(CTL, 8'h08);
        wr(CS, 8'h00);
        wr(CTL, 8'h18);
        wr(CTL, 8'h00);
        rdchk(CTL, 8'h00);
        $display("test combined mode done");

        alwaysOnFuse = 1'b1;
        idle(4);
        rdchk(CTL, 8'h08);
        wr(CTL, 8'h40);
        rdchk(CTL, 8'h08);
        // forced reset mode must really time out and reset
        wait_hi(1, 9000, n);
        idle(1);
        `CHK(sysResetPulse, 1'b0);
        rdchk(CS, 8'h08);
        rdchk(CTL, 8'h08);
        $display("test fuse done");
        wrap_up();
    end

endmodule : wdr_watchdog_tb
